// *** gpio_port_consts.vh ***
// Constants for the eight-pin I/O port with PWM hand-over.
// Assumes inclusion by bare name from gpio_port and the testbench; the synchroniser and the mux do not include it.
`ifndef GPIO_PORT_CONSTS_VH
`define GPIO_PORT_CONSTS_VH

// ****************************************************************
// Register map (byte addresses on the register bus)
// ****************************************************************
`define OFS_PORT_DIRECTION      8'h00
`define OFS_PORT_OUTPUT_DATA    8'h04
`define OFS_PORT_PULLUP_ENABLE  8'h08

// ****************************************************************
// Reset values and field layout
// ****************************************************************
`define RST_PORT_DIRECTION      8'h00
`define RST_PORT_OUTPUT_DATA    8'h00
`define RST_PORT_PULLUP_ENABLE  8'h00
`define PORT_FIELD_MSB          7
`define PORT_FIELD_LSB          0
`define READ_PAD_ZERO           24'h000000

// ****************************************************************
// Decode results and bus response codes
// ****************************************************************
`define SEL_NONE                2'h0
`define SEL_DIRECTION           2'h1
`define SEL_OUTPUT_DATA         2'h2
`define SEL_PULLUP_ENABLE       2'h3
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2

`endif

// *** pin_sync.v ***
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes the levels change slowly against aclk; no bus coherence is promised.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter WIDTH = 9
) (
  // Clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // Levels
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] stable_reg;

  // First stage is read only by the second stage
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg   <= {WIDTH{1'b0}};
      stable_reg <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_reg   <= async_in;
      stable_reg <= meta_reg;
    end
  end

  assign sync_out = stable_reg;

endmodule
`default_nettype wire

// *** pin_mux.v ***
// Per-pin function selection and pull-up gating for the eight-pin port.
// Assumes all inputs are on aclk; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module pin_mux #(
  parameter WIDTH = 8
) (
  // Register state
  input  wire [WIDTH-1:0] direction,
  input  wire [WIDTH-1:0] output_data,
  input  wire [WIDTH-1:0] pullup_enable,
  // PWM unit
  input  wire [WIDTH-1:0] pwm_channel_output_enable,
  input  wire [WIDTH-1:0] pwm_channel_outputs,
  // Conditions
  input  wire             pullup_block,
  input  wire [WIDTH-1:0] port_pins_level,
  // Results
  output reg  [WIDTH-1:0] pin_out_next,
  output reg  [WIDTH-1:0] pin_oe_next,
  output reg  [WIDTH-1:0] pullup_next,
  output reg  [WIDTH-1:0] port_read_value
);

  integer i;

  always @*
  begin
    pin_out_next    = {WIDTH{1'b0}};
    pin_oe_next     = {WIDTH{1'b0}};
    pullup_next     = {WIDTH{1'b0}};
    port_read_value = {WIDTH{1'b0}};
    for (i = 0; i < WIDTH; i = i + 1)
    begin
      pin_oe_next[i] = direction[i];
      if (direction[i] && pwm_channel_output_enable[i])
        pin_out_next[i] = pwm_channel_outputs[i];
      else if (direction[i])
        pin_out_next[i] = output_data[i];
      // Output pins read back the latch, not the pad, so a loaded pin reads as written
      port_read_value[i] = direction[i] ? output_data[i] : port_pins_level[i];
      pullup_next[i] = !pullup_block && !direction[i] && pullup_enable[i];
    end
  end

endmodule
`default_nettype wire

// *** gpio_port.v ***
// Eight-pin general I/O port with per-pin PWM hand-over, AXI4-Lite register slave.
// Assumes pins and the hardware standby pin are asynchronous to aclk;
// PWM enables, PWM outputs and software standby come from aclk logic.
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "gpio_port_consts.vh"
`default_nettype none
module gpio_port #(
  parameter ADDR_W = 8,
  parameter WIDTH  = 8
) (
  // Clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] awaddr,
  input  wire [2:0]        awprot,
  input  wire              awvalid,
  output wire              awready,
  // AXI4-Lite write data
  input  wire [31:0]       wdata,
  input  wire [3:0]        wstrb,
  input  wire              wvalid,
  output wire              wready,
  // AXI4-Lite write response
  output wire [1:0]        bresp,
  output wire              bvalid,
  input  wire              bready,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] araddr,
  input  wire [2:0]        arprot,
  input  wire              arvalid,
  output wire              arready,
  // AXI4-Lite read data
  output wire [31:0]       rdata,
  output wire [1:0]        rresp,
  output wire              rvalid,
  input  wire              rready,
  // Port pins
  input  wire [WIDTH-1:0]  port_pins_in,
  output wire [WIDTH-1:0]  port_pins_out,
  output wire [WIDTH-1:0]  port_pins_oe,
  output wire [WIDTH-1:0]  port_pins_pullup,
  // PWM unit
  input  wire [WIDTH-1:0]  pwm_channel_output_enable,
  input  wire [WIDTH-1:0]  pwm_channel_outputs,
  // Power state
  input  wire              hw_standby,
  input  wire              sw_standby
);

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Shared by the write and read paths; low two bits are ignored
  function [1:0] reg_select;
    input [ADDR_W-1:0] addr;
    begin
      if ({addr[ADDR_W-1:2], 2'b00} == `OFS_PORT_DIRECTION)
        reg_select = `SEL_DIRECTION;
      else if ({addr[ADDR_W-1:2], 2'b00} == `OFS_PORT_OUTPUT_DATA)
        reg_select = `SEL_OUTPUT_DATA;
      else if ({addr[ADDR_W-1:2], 2'b00} == `OFS_PORT_PULLUP_ENABLE)
        reg_select = `SEL_PULLUP_ENABLE;
      else
        reg_select = `SEL_NONE;
    end
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [WIDTH-1:0]  port_direction_reg;
  reg  [WIDTH-1:0]  port_output_data_reg;
  reg  [WIDTH-1:0]  port_pullup_enable_reg;
  reg  [WIDTH-1:0]  pin_out_reg;
  reg  [WIDTH-1:0]  pin_oe_reg;
  reg  [WIDTH-1:0]  pullup_reg;

  reg               aw_held_reg;
  reg  [ADDR_W-1:0] aw_addr_reg;
  reg               w_held_reg;
  reg  [31:0]       w_data_reg;
  reg  [3:0]        w_strb_reg;
  reg               bvalid_reg;
  reg  [1:0]        bresp_reg;
  reg               rvalid_reg;
  reg  [1:0]        rresp_reg;
  reg  [31:0]       rdata_reg;

  wire [WIDTH:0]    sync_levels;
  wire [WIDTH-1:0]  pins_level;
  wire              hw_standby_sync;
  wire [WIDTH-1:0]  pin_out_next;
  wire [WIDTH-1:0]  pin_oe_next;
  wire [WIDTH-1:0]  pullup_next;
  wire [WIDTH-1:0]  port_read_value;
  wire              pullup_block;

  wire              aw_take;
  wire              w_take;
  wire              have_aw;
  wire              have_w;
  wire [ADDR_W-1:0] wr_addr;
  wire [31:0]       wr_data;
  wire [3:0]        wr_strb;
  wire              wr_fire;
  wire [1:0]        wr_sel;
  wire              ar_take;
  wire [1:0]        rd_sel;

  // ****************************************************************
  // Pin and standby synchronisation
  // ****************************************************************
  pin_sync #(
    .WIDTH    (WIDTH + 1)
  ) u_pin_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({hw_standby, port_pins_in}),
    .sync_out (sync_levels)
  );

  assign pins_level      = sync_levels[WIDTH-1:0];
  assign hw_standby_sync = sync_levels[WIDTH];

  // Software standby keeps pull-ups under register control, so it does not block them
  assign pullup_block = hw_standby_sync;

  // ****************************************************************
  // Pin function
  // ****************************************************************
  pin_mux #(
    .WIDTH                     (WIDTH)
  ) u_pin_mux (
    .direction                 (port_direction_reg),
    .output_data               (port_output_data_reg),
    .pullup_enable             (port_pullup_enable_reg),
    .pwm_channel_output_enable (pwm_channel_output_enable),
    .pwm_channel_outputs       (pwm_channel_outputs),
    .pullup_block              (pullup_block),
    .port_pins_level           (pins_level),
    .pin_out_next              (pin_out_next),
    .pin_oe_next               (pin_oe_next),
    .pullup_next               (pullup_next),
    .port_read_value           (port_read_value)
  );

  // Pin drive is registered; PWM edges reach the pad one aclk late
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_out_reg <= {WIDTH{1'b0}};
      pin_oe_reg  <= {WIDTH{1'b0}};
      pullup_reg  <= {WIDTH{1'b0}};
    end
    else
    begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg  <= pin_oe_next;
      pullup_reg  <= pullup_next;
    end
  end

  assign port_pins_out    = pin_out_reg;
  assign port_pins_oe     = pin_oe_reg;
  // Gated by reset too, so pull-ups are off from the first reset cycle
  assign port_pins_pullup = pullup_reg & {WIDTH{aresetn}};

  // ****************************************************************
  // Write channel
  // ****************************************************************

  // Address and data are taken in either order; a new pair waits for the response
  assign awready = !aw_held_reg && !bvalid_reg;
  assign wready  = !w_held_reg && !bvalid_reg;
  assign aw_take = awvalid && awready;
  assign w_take  = wvalid && wready;
  assign have_aw = aw_held_reg || aw_take;
  assign have_w  = w_held_reg || w_take;
  assign wr_fire = have_aw && have_w && !bvalid_reg;
  assign wr_addr = aw_held_reg ? aw_addr_reg : awaddr;
  assign wr_data = w_held_reg ? w_data_reg : wdata;
  assign wr_strb = w_held_reg ? w_strb_reg : wstrb;
  assign wr_sel  = reg_select(wr_addr);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
    end
    else
    begin
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (wr_sel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end
      else
      begin
        if (aw_take)
        begin
          aw_held_reg <= 1'b1;
          aw_addr_reg <= awaddr;
        end
        if (w_take)
        begin
          w_held_reg <= 1'b1;
          w_data_reg <= wdata;
          w_strb_reg <= wstrb;
        end
        if (bvalid_reg && bready)
          bvalid_reg <= 1'b0;
      end
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp  = bresp_reg;

  // ****************************************************************
  // Port registers
  // ****************************************************************

  // Only byte lane 0 carries register bits; other lanes are ignored
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_direction_reg     <= `RST_PORT_DIRECTION;
      port_output_data_reg   <= `RST_PORT_OUTPUT_DATA;
      port_pullup_enable_reg <= `RST_PORT_PULLUP_ENABLE;
    end
    else if (wr_fire && wr_strb[0])
    begin
      case (wr_sel)
        `SEL_DIRECTION:
          port_direction_reg <= wr_data[`PORT_FIELD_MSB:`PORT_FIELD_LSB];
        `SEL_OUTPUT_DATA:
          port_output_data_reg <= wr_data[`PORT_FIELD_MSB:`PORT_FIELD_LSB];
        `SEL_PULLUP_ENABLE:
          port_pullup_enable_reg <= wr_data[`PORT_FIELD_MSB:`PORT_FIELD_LSB];
        default:
          port_direction_reg <= port_direction_reg;
      endcase
    end
  end

  // ****************************************************************
  // Read channel
  // ****************************************************************
  assign arready = !rvalid_reg;
  assign ar_take = arvalid && arready;
  assign rd_sel  = reg_select(araddr);

  // Direction is write-only and reads as zero; the data offset returns the port view
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `RESP_OKAY;
      rdata_reg  <= 32'h00000000;
    end
    else if (ar_take)
    begin
      rvalid_reg <= 1'b1;
      case (rd_sel)
        `SEL_DIRECTION:
        begin
          rresp_reg <= `RESP_OKAY;
          rdata_reg <= 32'h00000000;
        end
        `SEL_OUTPUT_DATA:
        begin
          rresp_reg <= `RESP_OKAY;
          rdata_reg <= {`READ_PAD_ZERO, port_read_value};
        end
        `SEL_PULLUP_ENABLE:
        begin
          rresp_reg <= `RESP_OKAY;
          rdata_reg <= {`READ_PAD_ZERO, port_pullup_enable_reg};
        end
        default:
        begin
          rresp_reg <= `RESP_SLVERR;
          rdata_reg <= 32'h00000000;
        end
      endcase
    end
    else if (rvalid_reg && rready)
      rvalid_reg <= 1'b0;
  end

  assign rvalid = rvalid_reg;
  assign rresp  = rresp_reg;
  assign rdata  = rdata_reg;

endmodule
`default_nettype wire

// *** gpio_port_monitor.sv ***
// Checker for the eight-pin port: bus handshakes and pin relations.
// Assumes it is bound to gpio_port and that everything runs on aclk.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_monitor #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // Bus
  input wire logic             awvalid,
  input wire logic             awready,
  input wire logic             wvalid,
  input wire logic             wready,
  input wire logic [1:0]       bresp,
  input wire logic             bvalid,
  input wire logic             bready,
  input wire logic             arvalid,
  input wire logic             arready,
  input wire logic [31:0]      rdata,
  input wire logic             rvalid,
  input wire logic             rready,
  // Pins, PWM and power
  input wire logic [WIDTH-1:0] port_pins_out,
  input wire logic [WIDTH-1:0] port_pins_oe,
  input wire logic [WIDTH-1:0] port_pins_pullup,
  input wire logic [WIDTH-1:0] pwm_channel_output_enable,
  input wire logic [WIDTH-1:0] pwm_channel_outputs,
  input wire logic             hw_standby
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_taken;
    arvalid && arready;
  endsequence
  AST_WRITE_ANSWER: assert property (wr_taken |=> bvalid) else $error("write not answered");
  AST_READ_ANSWER: assert property (rd_taken |=> rvalid && rdata[31:8] == 24'h000000)
    else $error("read not answered");
  AST_RESP_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");
  AST_READ_HOLD: assert property (rvalid && !rready |=> rvalid && !arready && $stable(rdata))
    else $error("rdata dropped");
  AST_RESET_CLEAR: assert property ($past(!aresetn) |-> port_pins_oe == '0 && port_pins_pullup == '0)
    else $error("pins not clear after reset");
  AST_PULLUP_INPUT_ONLY: assert property ((port_pins_pullup & port_pins_oe) == '0)
    else $error("pull-up on output pin");
  AST_HW_STANDBY_OFF: assert property (hw_standby [*3] |=> port_pins_pullup == '0)
    else $error("pull-up on in standby");
  AST_OUT_INPUT_QUIET: assert property ((port_pins_out & ~port_pins_oe) == '0)
    else $error("input pin drives");
  AST_PWM_HANDOVER: assert property (((port_pins_out ^ $past(pwm_channel_outputs)) & port_pins_oe
    & $past(pwm_channel_output_enable)) == '0) else $error("pwm not handed over");
endmodule
bind gpio_port gpio_port_monitor #(.WIDTH(WIDTH)) i_mon (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .port_pins_out(port_pins_out), .port_pins_oe(port_pins_oe), .port_pins_pullup(port_pins_pullup),
  .pwm_channel_output_enable(pwm_channel_output_enable), .pwm_channel_outputs(pwm_channel_outputs),
  .hw_standby(hw_standby));
`default_nettype wire

// *** pin_pad_model.sv ***
// Pads and PWM unit outside the port.
// Assumes the device wins any contention; an open pad toggles every cycle.
`timescale 1ns/1ps
`default_nettype none
module pin_pad_model #(
  parameter WIDTH = 8
) (
  // Clock
  input wire logic            aclk,
  // Device side
  input wire logic [WIDTH-1:0] port_pins_out,
  input wire logic [WIDTH-1:0] port_pins_oe,
  input wire logic [WIDTH-1:0] port_pins_pullup,
  output logic [WIDTH-1:0]     port_pins_in,
  output var logic [WIDTH-1:0] pwm_channel_outputs,
  // Far-side drivers
  input wire logic [WIDTH-1:0] ext_val,
  input wire logic [WIDTH-1:0] ext_en
);
  logic [WIDTH-1:0] float_pat = '0;
  initial pwm_channel_outputs = '0;
  always @(posedge aclk)
  begin
    float_pat <= ~float_pat;
    pwm_channel_outputs <= pwm_channel_outputs + 1'b1;
  end
  // A pulled-up pad reads high; an open one gives nothing stable
  assign port_pins_in = (port_pins_oe & port_pins_out) | (~port_pins_oe & ext_en & ext_val)
    | (~port_pins_oe & ~ext_en & (port_pins_pullup | float_pat));
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for gpio_port with a register model in integers.
// Assumes the pad model sits on the pins and the PWM unit is free running.
`timescale 1ns/1ps
`include "gpio_port_consts.vh"
`default_nettype none
module testbench;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, hw_standby = 1'b0, sw_standby = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, pwm_en = 8'h00, ext_val = 8'h00, ext_en = 8'h00;
  logic [31:0] wdata = 32'h00000000, rd;
  logic [7:0]  pwm_seen;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [7:0]  pin_in, pin_out, pin_oe, pin_pu, pwm_out;
  integer      failures = 0, n_tests = 0, cycles = 0, seed = 32'hEB9BB5FA, i, m_dir, m_dout, m_pue;
  gpio_port i_gpio_port (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .port_pins_in(pin_in),
    .port_pins_out(pin_out), .port_pins_oe(pin_oe), .port_pins_pullup(pin_pu),
    .pwm_channel_output_enable(pwm_en), .pwm_channel_outputs(pwm_out), .hw_standby(hw_standby),
    .sw_standby(sw_standby));
  pin_pad_model i_pin_pad_model (.aclk(aclk), .port_pins_out(pin_out), .port_pins_oe(pin_oe),
    .port_pins_pullup(pin_pu), .port_pins_in(pin_in), .pwm_channel_outputs(pwm_out), .ext_val(ext_val),
    .ext_en(ext_en));
  always #12.5 aclk = ~aclk;
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task tally_and_finish;
    begin
      $display("compares %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp, input [31:0] mask, input string m);
    begin
      n_tests = n_tests + 1;
      if ((got & mask) !== (exp & mask))
      begin
        failures = failures + 1;
        $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      end
    end
  endtask
  // Both address and data are offered together; each is dropped when taken
  // Response ready is raised only once the response shows, so the slave must hold it
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    logic ad, wd, bd;
    begin
      ad = 1'b0;
      wd = 1'b0;
      bd = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!bd)
      begin
        @(posedge aclk);
        if (ad && wd && bvalid && bready)
        begin
          chk(bresp, er, 32'h3, "bresp");
          bready <= 1'b0;
          bd = 1'b1;
        end
        else if (ad && wd && bvalid)
          bready <= 1'b1;
        if (!ad && awready)
        begin
          awvalid <= 1'b0;
          ad = 1'b1;
        end
        if (!wd && wready)
        begin
          wvalid <= 1'b0;
          wd = 1'b1;
        end
      end
    end
  endtask
  task rdr(input [7:0] a, input [1:0] er);
    logic ad, dn;
    begin
      ad = 1'b0;
      dn = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      while (!dn)
      begin
        @(posedge aclk);
        if (ad && rvalid && rready)
        begin
          rd = rdata;
          chk(rresp, er, 32'h3, "rresp");
          rready <= 1'b0;
          dn = 1'b1;
        end
        else if (ad && rvalid)
          rready <= 1'b1;
        if (!ad && arready)
        begin
          arvalid <= 1'b0;
          ad = 1'b1;
        end
      end
    end
  endtask
  // Open input pads are masked out: they carry no defined level
  task pins;
    begin
      repeat (3) @(posedge aclk);
      pwm_seen = pwm_out;
      @(posedge aclk);
      chk(pin_oe, m_dir, 32'hFF, "direction");
      chk(pin_out, m_dir & m_dout, m_dir & ~pwm_en, "output data");
      chk(pin_out, pwm_seen, m_dir & pwm_en, "pwm hand-over");
      chk(pin_pu, ~m_dir & m_pue, 32'hFF, "pull-up");
      rdr(`OFS_PORT_OUTPUT_DATA, `RESP_OKAY);
      chk(rd, (m_dir & m_dout) | (~m_dir & ((ext_en & ext_val) | (~ext_en & m_pue))),
        32'hFFFFFF00 | m_dir | ext_en | m_pue, "port read");
      rdr(`OFS_PORT_PULLUP_ENABLE, `RESP_OKAY);
      chk(rd, m_pue, 32'hFFFFFFFF, "pull-up enable");
      rdr(`OFS_PORT_DIRECTION, `RESP_OKAY);
      chk(rd, 0, 32'hFFFFFFFF, "write-only");
    end
  endtask
  task wall;
    begin
      wr(`OFS_PORT_DIRECTION, m_dir, `RESP_OKAY);
      wr(`OFS_PORT_OUTPUT_DATA, m_dout, `RESP_OKAY);
      wr(`OFS_PORT_PULLUP_ENABLE, m_pue, `RESP_OKAY);
      m_dout = m_dout & 255;
      pins;
    end
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  always @(posedge aclk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      $display("MISMATCH t=%0t timeout", $time);
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (3) @(posedge aclk);
    chk(pin_pu, 0, 32'hFF, "pull-up in reset");
    aresetn <= 1'b1;
    ext_en <= 8'hFF;
    ext_val <= 8'hA5;
    m_dir = 0;
    m_dout = 0;
    m_pue = 0;
    pins;
    $display("test reset done");
    for (i = 0; i < 16; i = i + 1)
    begin
      m_dir = (i == 0) ? 255 : (i == 1) ? 0 : $random(seed) & 255;
      m_dout = $random(seed);
      m_pue = $random(seed) & 255;
      ext_val <= $random(seed);
      ext_en <= $random(seed);
      pwm_en <= $random(seed);
      wall;
    end
    $display("test random done");
    wr(8'h0C, 32'hFFFFFFFF, `RESP_SLVERR);
    rdr(8'h10, `RESP_SLVERR);
    chk(rd, 0, 32'hFFFFFFFF, "unmapped read");
    pins;
    $display("test unmapped done");
    m_dir = 0;
    m_dout = 0;
    m_pue = 255;
    ext_en <= 8'h00;
    wall;
    hw_standby <= 1'b1;
    repeat (5) @(posedge aclk);
    chk(pin_pu, 0, 32'hFF, "pull-up in standby");
    hw_standby <= 1'b0;
    sw_standby <= 1'b1;
    pins;
    sw_standby <= 1'b0;
    $display("test standby done");
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(pin_pu, 0, 32'hFF, "pull-up in reset");
    aresetn <= 1'b1;
    m_pue = 0;
    pins;
    m_dir = 255;
    wr(`OFS_PORT_DIRECTION, m_dir, `RESP_OKAY);
    pins;
    $display("test second reset done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
